// >>> include/xal_pkg.sv
// How it works
// RULE_01: every operand address carries the full section and offset, never a bank.
// RULE_02: add with carry sums acc, operand and carry; five arithmetic flags update.
// RULE_03: plain add sums acc and operand; same five arithmetic flags update.
// RULE_04: and of acc and operand to chosen target; only zero flag updates.
// RULE_05: or of acc and operand to chosen target; only zero flag updates.
// RULE_06: clear byte writes zero to memory; flags untouched.
// RULE_07: clear bit zeroes one selected bit, keeps others; flags untouched.
// RULE_08: complement of operand to memory or acc; zero flag updates.
// RULE_09: decimal adjust adds six per nibble over nine or flagged; result to memory.
// RULE_10: decimal adjust may change only carry, marking a sum beyond two digits.
// RULE_11: decrement operand by one to memory or acc; zero flag updates.
// RULE_12: increment operand by one to memory or acc; zero flag updates.
// RULE_13: move memory to acc, no flag changes.
// RULE_14: move acc to memory, no flag changes.
// RULE_15: rotate left, bit 7 into bit 0, carry untouched.
// RULE_16: rotate left through carry: bit 7 to carry, old carry to bit 0.
// RULE_17: rotate right, bit 0 into bit 7, no flag changes.
// RULE_18: rotate right through carry: bit 0 to carry, old carry to bit 7.
// RULE_19: acc-target variants never write the memory byte.
// RULE_20: subtract with borrow: acc minus operand minus inverted carry; six flags update.
// RULE_21: subtract with borrow clears carry on negative, sets it on zero or positive.
// RULE_22: memory form of subtract with borrow writes difference back to memory.
// RULE_23: eight-bit operands, wrap modulo 256, carry from bit beyond msb.
package xal_pkg;

    localparam int          DATA_W       = 8;
    localparam logic [7:0]  ACC_RST      = 8'h00;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    localparam logic [7:0]  ONE_BYTE     = 8'h01;
    localparam logic [7:0]  DAA_LO_ADJ   = 8'h06;
    localparam logic [7:0]  DAA_HI_ADJ   = 8'h60;
    localparam logic [3:0]  BCD_MAX      = 4'h9;

    // operation codes presented by the sequencer
    typedef enum logic [4:0] {
        OP_ADD_CARRY_TO_ACC  = 5'h00, OP_ADD_CARRY_TO_MEM = 5'h01,
        OP_ADD_TO_ACC        = 5'h02, OP_ADD_TO_MEM       = 5'h03,
        OP_AND_TO_ACC        = 5'h04, OP_AND_TO_MEM       = 5'h05,
        OP_OR_TO_ACC         = 5'h06, OP_OR_TO_MEM        = 5'h07,
        OP_CLEAR_BYTE        = 5'h08, OP_CLEAR_BIT        = 5'h09,
        OP_COMPLEMENT_MEM    = 5'h0A, OP_COMPLEMENT_TO_ACC = 5'h0B,
        OP_DECIMAL_ADJUST    = 5'h0C, OP_DECREMENT_MEM    = 5'h0D,
        OP_DECREMENT_TO_ACC  = 5'h0E, OP_INCREMENT_MEM    = 5'h0F,
        OP_INCREMENT_TO_ACC  = 5'h10, OP_MOVE_TO_ACC      = 5'h11,
        OP_MOVE_TO_MEM       = 5'h12, OP_ROTATE_LEFT      = 5'h13,
        OP_ROTATE_LEFT_TO_ACC = 5'h14, OP_ROTATE_LEFT_CARRY = 5'h15,
        OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h16, OP_ROTATE_RIGHT = 5'h17,
        OP_ROTATE_RIGHT_TO_ACC = 5'h18, OP_ROTATE_RIGHT_CARRY = 5'h19,
        OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h1A, OP_SUBTRACT_BORROW_TO_ACC = 5'h1B,
        OP_SUBTRACT_BORROW_TO_MEM = 5'h1C
    } xal_op_e;

    // status flags held by the block
    typedef struct packed {
        logic chained_zero_flag;
        logic sign_compare_flag;
        logic signed_wrap_flag;
        logic half_carry_flag;
        logic zero;
        logic carry;
    } xal_flags_s;

    localparam xal_flags_s FLAGS_RST = '0;

    // one request from the sequencer
    typedef struct packed {
        xal_op_e    op;
        logic [2:0] bit_sel;
    } xal_req_s;

    // adder result with its two carries
    typedef struct packed {
        logic       carry;
        logic       half;
        logic [7:0] sum;
    } xal_sum_s;

endpackage : xal_pkg

// >>> src/xal_ext_alu.sv
`timescale 1ns/1ps
module xal_ext_alu #(
    parameter int ADDR_W = 12
) (
    input  wire logic               CORE_CLK,
    input  wire logic               RESET_N,
    input  wire logic               OP_VALID,
    output logic                    OP_READY,
    input  wire xal_pkg::xal_req_s  OP_REQ,
    input  wire logic [ADDR_W-1:0]  OP_ADDR,
    output logic [ADDR_W-1:0]       MEM_ADDR,
    output logic                    MEM_RD,
    input  wire logic [7:0]         MEM_RDATA,
    output logic                    MEM_WR,
    output logic [7:0]              MEM_WDATA,
    output logic [7:0]              ACC,
    output xal_pkg::xal_flags_s     FLAGS,
    output logic                    OP_DONE
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b10
    } xal_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // 8-bit add with carry-in; also serves subtract with the operand inverted
    function automatic xal_pkg::xal_sum_s add8(input logic [7:0] a, input logic [7:0] b,
                                               input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return '{carry: full[8], half: low[4], sum: full[7:0]};
    endfunction : add8

    // signed overflow of a + b giving r
    function automatic logic wrap8(input logic [7:0] a, input logic [7:0] b,
                                   input logic [7:0] r);
        return (a[7] == b[7]) && (r[7] != a[7]);
    endfunction : wrap8

    // memory-target variants, everything else lands in the accumulator
    function automatic logic to_mem(input xal_pkg::xal_op_e op);
        case (op)
            xal_pkg::OP_ADD_CARRY_TO_MEM, xal_pkg::OP_ADD_TO_MEM,
            xal_pkg::OP_AND_TO_MEM, xal_pkg::OP_OR_TO_MEM,
            xal_pkg::OP_CLEAR_BYTE, xal_pkg::OP_CLEAR_BIT,
            xal_pkg::OP_COMPLEMENT_MEM, xal_pkg::OP_DECIMAL_ADJUST,
            xal_pkg::OP_DECREMENT_MEM, xal_pkg::OP_INCREMENT_MEM,
            xal_pkg::OP_MOVE_TO_MEM, xal_pkg::OP_ROTATE_LEFT,
            xal_pkg::OP_ROTATE_LEFT_CARRY, xal_pkg::OP_ROTATE_RIGHT,
            xal_pkg::OP_ROTATE_RIGHT_CARRY, xal_pkg::OP_SUBTRACT_BORROW_TO_MEM:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : to_mem

    // ops that never look at the memory operand skip the read cycle
    function automatic logic needs_read(input xal_pkg::xal_op_e op);
        return !(op == xal_pkg::OP_CLEAR_BYTE || op == xal_pkg::OP_MOVE_TO_MEM ||
                 op == xal_pkg::OP_DECIMAL_ADJUST);
    endfunction : needs_read

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing

    xal_state_e          st_q;
    xal_pkg::xal_req_s   req_q;
    logic [ADDR_W-1:0]   addr_q;
    logic                mem_rd_q;
    logic                mem_wr_q;
    logic [7:0]          mem_wdata_q;
    logic [7:0]          acc_q;
    xal_pkg::xal_flags_s flags_q;
    logic                done_q;
    logic                accept;

    assign accept   = OP_VALID && OP_READY;
    assign OP_READY = (st_q == ST_IDLE);
    assign MEM_ADDR = addr_q;
    assign MEM_RD   = mem_rd_q;
    assign MEM_WR   = mem_wr_q;
    assign MEM_WDATA = mem_wdata_q;
    assign ACC      = acc_q;
    assign FLAGS    = flags_q;
    assign OP_DONE  = done_q;

    // state walk: idle, optional read, one execute cycle
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            st_q <= ST_IDLE;
        else
        begin
            case (st_q)
                ST_IDLE: if (accept) st_q <= needs_read(OP_REQ.op) ? ST_READ : ST_EXEC;
                ST_READ: st_q <= ST_EXEC;
                ST_EXEC: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // request and full data-memory address held for the whole operation
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            req_q  <= '{op: xal_pkg::OP_MOVE_TO_ACC, bit_sel: 3'h0};
            addr_q <= '0;
        end
        else if (accept)
        begin
            req_q  <= OP_REQ;
            addr_q <= OP_ADDR; // see RULE_01
        end
    end

    // read strobe high for exactly the read cycle; data arrives one cycle later
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            mem_rd_q <= 1'b0;
        else
            mem_rd_q <= accept && needs_read(OP_REQ.op);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // datapath

    xal_pkg::xal_sum_s   add_res;
    xal_pkg::xal_sum_s   sub_res;
    logic [7:0]          m;
    logic [7:0]          res;
    logic [7:0]          daa_adj;
    logic                daa_hi;
    xal_pkg::xal_flags_s flags_d;

    assign m = MEM_RDATA;

    // carry-in is zero for the plain add; the borrow form adds ~m plus carry
    assign add_res = add8(acc_q, m, (req_q.op == xal_pkg::OP_ADD_CARRY_TO_ACC ||
                                    req_q.op == xal_pkg::OP_ADD_CARRY_TO_MEM) &&
                                    flags_q.carry); // see RULE_02 RULE_03 RULE_23
    assign sub_res = add8(acc_q, ~m, flags_q.carry); // see RULE_20 RULE_21

    // decimal adjust looks only at the accumulator and the two carries
    assign daa_hi  = (acc_q[7:4] > xal_pkg::BCD_MAX) || flags_q.carry;
    assign daa_adj = (((acc_q[3:0] > xal_pkg::BCD_MAX) || flags_q.half_carry_flag) ?
                      xal_pkg::DAA_LO_ADJ : xal_pkg::ZERO_BYTE) |
                     (daa_hi ? xal_pkg::DAA_HI_ADJ : xal_pkg::ZERO_BYTE); // see RULE_09

    // result and next flags; untouched flags keep their value by default
    always_comb
    begin
        res     = m;
        flags_d = flags_q;
        case (req_q.op)
            xal_pkg::OP_ADD_CARRY_TO_ACC, xal_pkg::OP_ADD_CARRY_TO_MEM,
            xal_pkg::OP_ADD_TO_ACC, xal_pkg::OP_ADD_TO_MEM:
            begin
                res = add_res.sum; // see RULE_02 RULE_03
                flags_d.carry             = add_res.carry;
                flags_d.half_carry_flag   = add_res.half;
                flags_d.signed_wrap_flag  = wrap8(acc_q, m, res);
                flags_d.zero              = (res == xal_pkg::ZERO_BYTE);
                flags_d.sign_compare_flag = flags_d.signed_wrap_flag ^ res[7];
            end
            xal_pkg::OP_SUBTRACT_BORROW_TO_ACC, xal_pkg::OP_SUBTRACT_BORROW_TO_MEM:
            begin
                res = sub_res.sum; // see RULE_20 RULE_22
                flags_d.carry             = sub_res.carry; // see RULE_21
                flags_d.half_carry_flag   = sub_res.half;
                flags_d.signed_wrap_flag  = wrap8(acc_q, ~m, res);
                flags_d.zero              = (res == xal_pkg::ZERO_BYTE);
                flags_d.sign_compare_flag = flags_d.signed_wrap_flag ^ res[7];
                // zero across a chain of bytes: previous bytes must be zero too
                flags_d.chained_zero_flag = flags_d.zero && flags_q.chained_zero_flag;
            end
            xal_pkg::OP_AND_TO_ACC, xal_pkg::OP_AND_TO_MEM:
            begin
                res = acc_q & m; // see RULE_04
                flags_d.zero = (res == xal_pkg::ZERO_BYTE);
            end
            xal_pkg::OP_OR_TO_ACC, xal_pkg::OP_OR_TO_MEM:
            begin
                res = acc_q | m; // see RULE_05
                flags_d.zero = (res == xal_pkg::ZERO_BYTE);
            end
            xal_pkg::OP_CLEAR_BYTE:
                res = xal_pkg::ZERO_BYTE; // see RULE_06
            xal_pkg::OP_CLEAR_BIT:
                res = m & ~(xal_pkg::ONE_BYTE << req_q.bit_sel); // see RULE_07
            xal_pkg::OP_COMPLEMENT_MEM, xal_pkg::OP_COMPLEMENT_TO_ACC:
            begin
                res = ~m; // see RULE_08
                flags_d.zero = (res == xal_pkg::ZERO_BYTE);
            end
            xal_pkg::OP_DECIMAL_ADJUST:
            begin
                res = acc_q + daa_adj; // see RULE_09 RULE_23
                // a high digit past 9 forces the carry so multi-byte bcd can continue
                flags_d.carry = flags_q.carry || daa_hi; // see RULE_10
            end
            xal_pkg::OP_DECREMENT_MEM, xal_pkg::OP_DECREMENT_TO_ACC:
            begin
                res = m - xal_pkg::ONE_BYTE; // see RULE_11
                flags_d.zero = (res == xal_pkg::ZERO_BYTE);
            end
            xal_pkg::OP_INCREMENT_MEM, xal_pkg::OP_INCREMENT_TO_ACC:
            begin
                res = m + xal_pkg::ONE_BYTE; // see RULE_12
                flags_d.zero = (res == xal_pkg::ZERO_BYTE);
            end
            xal_pkg::OP_MOVE_TO_ACC:
                res = m; // see RULE_13
            xal_pkg::OP_MOVE_TO_MEM:
                res = acc_q; // see RULE_14
            xal_pkg::OP_ROTATE_LEFT, xal_pkg::OP_ROTATE_LEFT_TO_ACC:
                res = {m[6:0], m[7]}; // see RULE_15
            xal_pkg::OP_ROTATE_LEFT_CARRY, xal_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC:
            begin
                res = {m[6:0], flags_q.carry}; // see RULE_16
                flags_d.carry = m[7];
            end
            xal_pkg::OP_ROTATE_RIGHT, xal_pkg::OP_ROTATE_RIGHT_TO_ACC:
                res = {m[0], m[7:1]}; // see RULE_17
            xal_pkg::OP_ROTATE_RIGHT_CARRY, xal_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC:
            begin
                res = {flags_q.carry, m[7:1]}; // see RULE_18
                flags_d.carry = m[0];
            end
            default:
                res = m;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result write-back

    // accumulator updates only for acc-target ops, in the execute cycle
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            acc_q <= xal_pkg::ACC_RST;
        else if (st_q == ST_EXEC && !to_mem(req_q.op))
            acc_q <= res;
    end

    // flags commit with the result
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            flags_q <= xal_pkg::FLAGS_RST;
        else if (st_q == ST_EXEC)
            flags_q <= flags_d;
    end

    // memory write is a one-cycle strobe after execute; acc targets never write
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            mem_wr_q    <= 1'b0;
            mem_wdata_q <= xal_pkg::ZERO_BYTE;
            done_q      <= 1'b0;
        end
        else
        begin
            mem_wr_q <= (st_q == ST_EXEC) && to_mem(req_q.op); // see RULE_19
            done_q   <= (st_q == ST_EXEC);
            if (st_q == ST_EXEC)
                mem_wdata_q <= res;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    acc_no_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_19
        (st_q == ST_EXEC && !to_mem(req_q.op)) |=> !MEM_WR)
        else $error("acc-target op wrote memory");

    add_sum_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_03
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_ADD_TO_ACC)
        |=> ACC == 8'($past(acc_q) + $past(MEM_RDATA)))
        else $error("plain add result wrong");

    adc_carry_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_02
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_ADD_CARRY_TO_MEM)
        |=> MEM_WR && FLAGS.carry == (({1'b0, $past(acc_q)} + {1'b0, $past(MEM_RDATA)}
             + {8'h00, $past(flags_q.carry)}) > 9'h0FF))
        else $error("add with carry carry-out wrong");

    sbc_carry_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_21
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_SUBTRACT_BORROW_TO_ACC)
        |=> FLAGS.carry == ({1'b0, $past(acc_q)} >= ({1'b0, $past(MEM_RDATA)}
             + {8'h00, !$past(flags_q.carry)})))
        else $error("borrow carry sense wrong");

    sbc_mem_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_22
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_SUBTRACT_BORROW_TO_MEM)
        |=> MEM_WR && MEM_WDATA == 8'($past(acc_q) - $past(MEM_RDATA)
             - {7'h00, !$past(flags_q.carry)}))
        else $error("borrow difference to memory wrong");

    clr_flags_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_06
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_CLEAR_BYTE)
        |=> MEM_WR && MEM_WDATA == 8'h00 && $stable(FLAGS))
        else $error("clear byte wrong");

    daa_only_c_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_10
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_DECIMAL_ADJUST)
        |=> FLAGS[5:1] == $past(flags_q[5:1]) && ACC == $past(acc_q))
        else $error("decimal adjust disturbed other state");

    rlc_carry_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_16
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC)
        |=> FLAGS.carry == $past(MEM_RDATA[7]) && ACC[0] == $past(flags_q.carry))
        else $error("rotate through carry wrong");

    rr_wrap_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_17
        (st_q == ST_EXEC && req_q.op == xal_pkg::OP_ROTATE_RIGHT)
        |=> MEM_WDATA[7] == $past(MEM_RDATA[0]) && $stable(FLAGS))
        else $error("rotate right wrong");

    read_then_exec_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RULE_01
        (accept && needs_read(OP_REQ.op)) |=> MEM_RD && MEM_ADDR == $past(OP_ADDR)
        ##1 !MEM_RD && st_q == ST_EXEC ##1 OP_DONE)
        else $error("read sequence wrong");

endmodule : xal_ext_alu

// >>> sim/xal_mem_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// data memory partner: answers a read one cycle later, no wait states
module xal_mem_model #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              rd,
    input  wire logic              wr,
    input  wire logic [7:0]        wdata,
    output logic [7:0]             rdata
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] rdata_q = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // read data lasts one cycle; outside it the bus toggles so stale data never matches
    always @(posedge clk)
    begin
        if (rd === 1'b1)
            rdata_q <= mem[addr];
        else
            rdata_q <= ~rdata_q;
        if (wr === 1'b1)
            mem[addr] <= wdata;
    end

    assign rdata = rdata_q;
endmodule : xal_mem_model

// >>> sim/test_extended_memory_alu_ops.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module test_extended_memory_alu_ops;
    logic                core_clk;
    logic                reset_n;
    logic                op_valid;
    logic                op_ready;
    logic                mem_rd;
    logic                mem_wr;
    logic                op_done;
    xal_pkg::xal_req_s   req;
    logic [11:0]         op_addr;
    logic [11:0]         mem_addr;
    logic [7:0]          mem_rdata;
    logic [7:0]          mem_wdata;
    logic [7:0]          acc;
    xal_pkg::xal_flags_s flags;
    xal_pkg::xal_flags_s exp_f;
    logic [7:0]          exp_acc;
    int                  error_cnt = 0;
    int                  checks_done = 0;
    int                  wr_cnt = 0;
    int unsigned         seed_v;

    xal_ext_alu #(.ADDR_W(12)) DUT (.CORE_CLK(core_clk), .RESET_N(reset_n),
        .OP_VALID(op_valid), .OP_READY(op_ready), .OP_REQ(req), .OP_ADDR(op_addr),
        .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata), .MEM_WR(mem_wr),
        .MEM_WDATA(mem_wdata), .ACC(acc), .FLAGS(flags), .OP_DONE(op_done));

    xal_mem_model #(.ADDR_W(12)) mem (.clk(core_clk), .addr(mem_addr), .rd(mem_rd),
        .wr(mem_wr), .wdata(mem_wdata), .rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////////
    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;

    // count memory writes so acc-target forms can be shown to leave memory alone
    always @(posedge core_clk)
    begin
        if (mem_wr === 1'b1)
            wr_cnt <= wr_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // expected acc, memory byte, flags, write and latency for one operation
    function automatic void xref(input xal_pkg::xal_op_e op, input logic [2:0] bs,
        input logic [7:0] a, input logic [7:0] m, input xal_pkg::xal_flags_s f,
        output logic [7:0] na, output logic [7:0] nm, output xal_pkg::xal_flags_s nf,
        output logic wr, output logic [7:0] lat);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b;
        logic [7:0] r;
        logic       ci;
        logic       ar;
        logic       zu;
        logic       hi;
        na = a;
        nm = m;
        nf = f;
        lat = 8'h03;
        ci = f.carry;
        b = m;
        r = m;
        ar = 1'b0;
        zu = 1'b1;
        hi = (a[7:4] > 4'h9) || f.carry;
        case (op)
            xal_pkg::OP_ADD_TO_ACC, xal_pkg::OP_ADD_TO_MEM: {ci, ar} = 2'b01;
            xal_pkg::OP_ADD_CARRY_TO_ACC, xal_pkg::OP_ADD_CARRY_TO_MEM: ar = 1'b1;
            xal_pkg::OP_SUBTRACT_BORROW_TO_ACC, xal_pkg::OP_SUBTRACT_BORROW_TO_MEM:
                {b, ar} = {~m, 1'b1};
            xal_pkg::OP_AND_TO_ACC, xal_pkg::OP_AND_TO_MEM: r = a & m;
            xal_pkg::OP_OR_TO_ACC, xal_pkg::OP_OR_TO_MEM: r = a | m;
            xal_pkg::OP_COMPLEMENT_MEM, xal_pkg::OP_COMPLEMENT_TO_ACC: r = ~m;
            xal_pkg::OP_DECREMENT_MEM, xal_pkg::OP_DECREMENT_TO_ACC: r = m - 8'h01;
            xal_pkg::OP_INCREMENT_MEM, xal_pkg::OP_INCREMENT_TO_ACC: r = m + 8'h01;
            xal_pkg::OP_CLEAR_BYTE: {r, zu, lat} = {8'h00, 1'b0, 8'h02};
            xal_pkg::OP_CLEAR_BIT: {r, zu} = {m & ~(8'h01 << bs), 1'b0};
            xal_pkg::OP_MOVE_TO_MEM: {r, zu, lat} = {a, 1'b0, 8'h02};
            xal_pkg::OP_DECIMAL_ADJUST:
            begin
                r = a + (((a[3:0] > 4'h9) || f.half_carry_flag) ? 8'h06 : 8'h00)
                    + (hi ? 8'h60 : 8'h00);
                {nf.carry, zu, lat} = {f.carry | hi, 1'b0, 8'h02};
            end
            xal_pkg::OP_ROTATE_LEFT, xal_pkg::OP_ROTATE_LEFT_TO_ACC:
                {r, zu} = {m[6:0], m[7], 1'b0};
            xal_pkg::OP_ROTATE_RIGHT, xal_pkg::OP_ROTATE_RIGHT_TO_ACC:
                {r, zu} = {m[0], m[7:1], 1'b0};
            xal_pkg::OP_ROTATE_LEFT_CARRY, xal_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC:
                {r, nf.carry, zu} = {m[6:0], f.carry, m[7], 1'b0};
            xal_pkg::OP_ROTATE_RIGHT_CARRY, xal_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC:
                {r, nf.carry, zu} = {f.carry, m[7:1], m[0], 1'b0};
            default: zu = 1'b0;
        endcase
        if (ar)
        begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
            h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
            r = s[7:0];
            nf.carry = s[8];
            nf.half_carry_flag = h[4];
            nf.signed_wrap_flag = (a[7] == b[7]) && (r[7] != a[7]);
            nf.sign_compare_flag = nf.signed_wrap_flag ^ r[7];
            if (b != m)
                nf.chained_zero_flag = (r == 8'h00) && f.chained_zero_flag;
        end
        if (zu)
            nf.zero = (r == 8'h00);
        wr = op inside {xal_pkg::OP_ADD_CARRY_TO_MEM, xal_pkg::OP_ADD_TO_MEM,
            xal_pkg::OP_AND_TO_MEM, xal_pkg::OP_OR_TO_MEM, xal_pkg::OP_CLEAR_BYTE,
            xal_pkg::OP_CLEAR_BIT, xal_pkg::OP_COMPLEMENT_MEM, xal_pkg::OP_DECIMAL_ADJUST,
            xal_pkg::OP_DECREMENT_MEM, xal_pkg::OP_INCREMENT_MEM, xal_pkg::OP_MOVE_TO_MEM,
            xal_pkg::OP_ROTATE_LEFT, xal_pkg::OP_ROTATE_LEFT_CARRY, xal_pkg::OP_ROTATE_RIGHT,
            xal_pkg::OP_ROTATE_RIGHT_CARRY, xal_pkg::OP_SUBTRACT_BORROW_TO_MEM};
        if (wr)
            nm = r;
        else
            na = r;
    endfunction : xref

    ////////////////////////////////////////////////////////////////////////////
    // byte and flag comparisons
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chkf(input xal_pkg::xal_flags_s exp, input xal_pkg::xal_flags_s got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR flags expected %b seen %b", exp, got);
        end
    endtask : chkf

    // one operation at a random address in any section; entered and left at a falling edge
    task automatic run_op(input xal_pkg::xal_op_e op, input logic [2:0] bs, input logic [7:0] m);
        logic [11:0] a;
        logic [7:0]  em;
        logic [7:0]  lat;
        logic [7:0]  xl;
        logic        ew;
        int          w0;
        a = 12'($urandom);
        mem.mem[a] = m;
        xref(op, bs, exp_acc, m, exp_f, exp_acc, em, exp_f, ew, xl);
        w0 = wr_cnt;
        op_valid = 1'b1;
        req.op = op;
        req.bit_sel = bs;
        op_addr = a;
        @(negedge core_clk);
        op_valid = 1'b0;
        lat = 8'h01;
        chk8("ready while busy", 8'h00, {7'b0, op_ready});
        while (op_done !== 1'b1 && lat < 8'd20)
        begin
            @(negedge core_clk);
            lat++;
        end
        @(negedge core_clk);
        chk8("latency", xl, lat);
        chk8("acc", exp_acc, acc);
        chkf(exp_f, flags);
        chk8("memory byte", em, mem.mem[a]);
        chk8("writes", {7'b0, ew}, 8'(wr_cnt - w0));
    endtask : run_op

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the roughly 1350 cycles the run needs
    initial
    begin
        #100us;
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        close_out();
    end

    // main sequence: reset, corner cases, every code once, then random traffic
    initial
    begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        op_valid = 1'b0;
        req = '0;
        op_addr = 12'h000;
        exp_acc = xal_pkg::ACC_RST;
        exp_f = xal_pkg::FLAGS_RST;
        seed_v = $urandom(32'h89eb_20ee);
        repeat (6) @(negedge core_clk);
        chk8("acc at reset", 8'h00, acc);
        chkf(xal_pkg::FLAGS_RST, flags);
        reset_n = 1'b1;
        run_op(xal_pkg::OP_MOVE_TO_ACC, 3'h0, 8'h7f);
        run_op(xal_pkg::OP_ADD_TO_ACC, 3'h0, 8'h01);
        run_op(xal_pkg::OP_ADD_TO_ACC, 3'h0, 8'h80);
        run_op(xal_pkg::OP_ADD_CARRY_TO_MEM, 3'h0, 8'hff);
        run_op(xal_pkg::OP_SUBTRACT_BORROW_TO_ACC, 3'h0, 8'h01);
        run_op(xal_pkg::OP_SUBTRACT_BORROW_TO_MEM, 3'h0, 8'h00);
        run_op(xal_pkg::OP_MOVE_TO_ACC, 3'h0, 8'h9a);
        run_op(xal_pkg::OP_DECIMAL_ADJUST, 3'h0, 8'h55);
        run_op(xal_pkg::OP_CLEAR_BIT, 3'h7, 8'hff);
        run_op(xal_pkg::OP_INCREMENT_TO_ACC, 3'h0, 8'hff);
        run_op(xal_pkg::OP_DECREMENT_MEM, 3'h0, 8'h00);
        run_op(xal_pkg::OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h01);
        run_op(xal_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC, 3'h0, 8'h80);
        $display("corner cases done, mismatches %0d", error_cnt);
        for (int k = 0; k <= 28; k++)
            run_op(xal_pkg::xal_op_e'(k[4:0]), 3'($urandom), 8'($urandom));
        $display("every operation code done, mismatches %0d", error_cnt);
        repeat (300)
            run_op(xal_pkg::xal_op_e'(5'($urandom_range(28, 0))), 3'($urandom), 8'($urandom));
        $display("random operations done, mismatches %0d", error_cnt);
        close_out();
    end
endmodule : test_extended_memory_alu_ops
